/* sim/pfs_pad_model.sv */
// Pad model for the pin function select block: resolves each pin from the block and an outside source.
// Assumes the testbench supplies the level that outside parts put on released pins.
`timescale 1ns/1ps
`default_nettype none
module pfs_pad_model (
  input wire logic [31:0] pad_out_i, // Level driven by the block.
  input wire logic [31:0] pad_oe_n_i, // Drive enables, low drives.
  input wire logic [31:0] ext_level_i, // Outside level on released pins.
  output logic [31:0] pad_level_o // Resolved pin level.
);
  // A released pin shows the outside level, never the block's stale output.
  assign pad_level_o = (pad_out_i & ~pad_oe_n_i) | (ext_level_i & pad_oe_n_i);
endmodule // pfs_pad_model
`default_nettype wire

/* sim/pfs_pin_mux_chk.sv */
// Checker for the pin function select block: bus answers and routing of pins 0 and 10 to 12.
// Assumes it is bound to pfs_pin_mux and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_mux_chk
  import pfs_pkg::*;
(
  input wire logic clock_i, // Clock.
  input wire logic reset_i, // Reset.
  input wire logic clk_en_i, // Clock enable.
  input wire logic psel_i, // Select.
  input wire logic penable_i, // Enable.
  input wire logic pwrite_i, // Direction.
  input wire logic [31:0] paddr_i, // Address.
  input wire logic [31:0] pwdata_i, // Write data.
  input wire logic [31:0] prdata_o, // Read data.
  input wire logic pready_o, // Ready.
  input wire logic pslverr_o, // Error.
  input wire logic [31:0] pad_in_i, // Pad levels.
  input wire logic [31:0] pad_out_o, // Pad outputs.
  input wire logic [31:0] pad_oe_n_o, // Pad enables.
  input wire logic [31:0] port_direction_reg_i, // GPIO direction.
  input wire logic uart_a_transmit_i, // UART A transmit.
  input wire logic [2:0] adc_level_o, // Converter levels.
  input wire logic [2:0] adc_valid_o // Converter valid.
);
  logic [31:0] sel_lo_r;
  logic [1:0] run_r;
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sel_lo_r <= PFS_RESET_SEL_LOW;
    end else if (clk_en_i && psel_i && penable_i && pready_o && pwrite_i && paddr_i == PFS_ADDR_SEL_LOW) begin
      sel_lo_r <= pwdata_i;
    end
  end
  // Counts clean cycles so that $past never looks into a reset or a frozen cycle.
  always_ff @(posedge clock_i) begin
    if (reset_i || !clk_en_i) begin
      run_r <= 2'h0;
    end else if (run_r != 2'h3) begin
      run_r <= run_r + 2'h1;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence setup_s;
    psel_i && !penable_i && clk_en_i;
  endsequence
  sequence access_s;
    psel_i && penable_i && clk_en_i;
  endsequence
  chk_zero_wait: assert property (setup_s ##1 access_s |-> pready_o)
    else $error("no ready in first access cycle");
  chk_bad_addr: assert property (pready_o && paddr_i != PFS_ADDR_SEL_LOW && paddr_i != PFS_ADDR_SEL_HIGH |-> pslverr_o)
    else $error("unmapped access without error");
  chk_read_low: assert property (pready_o && !pwrite_i && paddr_i == PFS_ADDR_SEL_LOW |-> prdata_o == sel_lo_r)
    else $error("low selector read differs");
  chk_gpio_dir: assert property (run_r != 2'h0 && $past(sel_lo_r[1:0]) == 2'h0 |-> pad_oe_n_o[0] == !$past(port_direction_reg_i[0]))
    else $error("gpio direction not applied");
  chk_uart_tx: assert property (run_r != 2'h0 && $past(sel_lo_r[1:0]) == 2'h1 |-> !pad_oe_n_o[0] && pad_out_o[0] == $past(uart_a_transmit_i))
    else $error("transmit not routed to pin 0");
  chk_reserved_off: assert property (run_r != 2'h0 && $past(sel_lo_r[1:0]) == 2'h3 |-> pad_oe_n_o[0] && !pad_out_o[0])
    else $error("reserved code drives pin 0");
  chk_adc_valid: assert property (run_r != 2'h0 |-> adc_valid_o == {$past(sel_lo_r[25:24]) == 2'h3,
    $past(sel_lo_r[23:22]) == 2'h3, $past(sel_lo_r[21:20]) == 2'h3})
    else $error("converter valid mismatch");
  chk_adc_level: assert property (run_r == 2'h3 |-> adc_level_o == $past(pad_in_i[12:10], 3))
    else $error("converter level not tracking pins");
endmodule // pfs_pin_mux_chk
bind pfs_pin_mux pfs_pin_mux_chk pfs_pin_mux_chk_inst (
  .clock_i(clock_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o),
  .port_direction_reg_i(port_direction_reg_i), .uart_a_transmit_i(uart_a_transmit_i),
  .adc_level_o(adc_level_o), .adc_valid_o(adc_valid_o)
);
`default_nettype wire

/* sim/tb_port_pin_function_select.sv */
// Testbench for the pin function select block: register access and routing of pins 0, 1, 10, 16, 31.
// Assumes pfs_pkg, pfs_pin_mux, the pad model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_port_pin_function_select;
  import pfs_pkg::*;
  localparam logic [3:0] OE0 = 4'h9, LV0 = 4'hb;
  localparam logic [7:0] RX1 = 8'h09;
  localparam logic [15:0] A10 = 16'ha766;
  logic clock_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, pready_o, pslverr_o;
  logic [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, prdata_o, pad_in_i, pad_out_o, pad_oe_n_o;
  logic [31:0] pad_digital_en_o, gpio_in_o, gpio_out_i = 32'h1, port_direction_reg_i = 32'h0, ext = 32'h403;
  logic [47:0] upper_alt_out_i = 48'h0, upper_alt_oe_n_i = 48'hffffffffffff, upper_alt_in_o;
  logic [2:0] adc_level_o, adc_valid_o;
  logic [22:0] drv = 23'h0;
  logic uart_a_transmit_i, t3_match_1_i, t3_match_2_i, i2c_a_clock_drive_low_i, i2c_a_data_drive_low_i;
  logic t0_match_0_i, spi_a_clock_out_i, spi_a_clock_oe_n_i, spi_a_master_in_out_i, spi_a_master_in_oe_n_i;
  logic spi_a_master_out_out_i, spi_a_master_out_oe_n_i, t0_match_1_i, t2_match_0_i, uart_b_transmit_i;
  logic t2_match_1_i, t2_match_2_i, uart_b_request_send_i, t1_match_0_i, t1_match_1_i;
  logic uart_b_terminal_ready_i, ssp_serial_clock_out_i, ssp_serial_clock_oe_n_i;
  logic uart_a_receive_o, i2c_a_clock_o, i2c_a_data_o, t0_capture_0_o, spi_a_clock_o, spi_a_master_in_o;
  logic spi_a_master_out_o, t0_capture_1_o, t0_capture_2_o, spi_a_select_o, uart_b_receive_o, t1_capture_0_o;
  logic uart_b_clear_send_o, t1_capture_1_o, uart_b_data_set_ready_o, ext_irq_1_o, ext_irq_2_o;
  logic ssp_serial_clock_o, uart_b_carrier_detect_o, uart_b_ring_o;
  int bad_count = 0, check_count = 0;
  assign {uart_a_transmit_i, t3_match_1_i, t3_match_2_i, i2c_a_clock_drive_low_i, i2c_a_data_drive_low_i,
    t0_match_0_i, spi_a_clock_out_i, spi_a_clock_oe_n_i, spi_a_master_in_out_i, spi_a_master_in_oe_n_i,
    spi_a_master_out_out_i, spi_a_master_out_oe_n_i, t0_match_1_i, t2_match_0_i, uart_b_transmit_i,
    t2_match_1_i, t2_match_2_i, uart_b_request_send_i, t1_match_0_i, t1_match_1_i,
    uart_b_terminal_ready_i, ssp_serial_clock_out_i, ssp_serial_clock_oe_n_i} = drv;
  pfs_pin_mux pfs_pin_mux_inst (.*);
  pfs_pad_model pfs_pad_model_inst (.pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o), .ext_level_i(ext),
    .pad_level_o(pad_in_i));
  always #50 clock_i = ~clock_i;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock_i);
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] er,
    input logic ee);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1);
    check("pready_wait", n, 32'h1);
    check("pslverr", pslverr_o, ee);
    if (!w) check("prdata", prdata_o, er);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    logic [31:0] w;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    apb(1'b0, PFS_ADDR_SEL_LOW, 32'h0, PFS_RESET_SEL_LOW, 1'b0);
    apb(1'b0, PFS_ADDR_SEL_HIGH, 32'h0, PFS_RESET_SEL_HIGH, 1'b0);
    for (int c = 0; c < 4; c++) begin
      w = 32'h00100005 * c;
      apb(1'b1, PFS_ADDR_SEL_LOW, w, 32'h0, 1'b0);
      // Peripherals start only once their pins are routed.
      drv <= 23'h400020;
      tick(4);
      apb(1'b0, PFS_ADDR_SEL_LOW, 32'h0, w, 1'b0);
      check("pin0", {pad_oe_n_o[0], pad_in_i[0]}, {OE0[c], LV0[c]});
      check("pin1", {uart_a_receive_o, gpio_in_o[1]}, RX1[2*c +: 2]);
      check("pin10", {adc_valid_o[0], pad_digital_en_o[10], adc_level_o[0], t1_capture_0_o}, A10[4*c +: 4]);
    end
    apb(1'b1, PFS_ADDR_SEL_LOW, 32'h0, 32'h0, 1'b0);
    port_direction_reg_i <= 32'h1;
    gpio_out_i <= 32'h0;
    tick(2);
    check("gpio", {pad_oe_n_o[0], pad_in_i[0]}, 2'h0);
    upper_alt_out_i <= 48'h400000000001;
    upper_alt_oe_n_i <= 48'hbffffffffffe;
    apb(1'b1, PFS_ADDR_SEL_HIGH, 32'h80000001, 32'h0, 1'b0);
    tick(2);
    check("upper", {pad_out_o[31], pad_out_o[16], pad_oe_n_o[31], pad_oe_n_o[16]}, 4'hc);
    apb(1'b1, PFS_ADDR_SEL_HIGH + 32'h4, 32'hffffffff, 32'h0, 1'b1);
    apb(1'b0, PFS_ADDR_SEL_HIGH + 32'h4, 32'h0, PFS_RDATA_UNMAPPED, 1'b1);
    apb(1'b0, PFS_ADDR_SEL_HIGH, 32'h0, 32'h80000001, 1'b0);
    // First alternates on pins 0 to 11, third alternates on pins 12 to 15.
    ext <= 32'h0000deaf;
    apb(1'b1, PFS_ADDR_SEL_LOW, 32'hff555555, 32'h0, 1'b0);
    drv <= 23'h093104;
    tick(6);
    check("rx_a", {uart_a_receive_o, i2c_a_clock_o, i2c_a_data_o}, 3'h5);
    check("rx_b", {uart_b_receive_o, uart_b_clear_send_o}, 2'h3);
    check("spi_in", {spi_a_clock_o, spi_a_master_in_o, spi_a_master_out_o, spi_a_select_o}, 4'hf);
    check("cap_off", {t0_capture_0_o, t0_capture_1_o, t0_capture_2_o, t1_capture_0_o, t1_capture_1_o}, 5'h0);
    check("irq_off", {uart_b_data_set_ready_o, ext_irq_1_o, ext_irq_2_o, ssp_serial_clock_o}, 4'h0);
    check("modem_in", {uart_b_carrier_detect_o, uart_b_ring_o}, 2'h3);
    check("gpio_in", gpio_in_o[15:0], 16'h0000);
    check("pads", {pad_oe_n_o[11:0], pad_out_o[8], pad_out_o[6], pad_out_o[4], pad_out_o[2]}, 16'haaae);
    check("pin12_13", {adc_valid_o, pad_digital_en_o[12:10], adc_level_o[2], pad_out_o[13], pad_oe_n_o[13]}, 9'h11e);
    check("upper_in_hi", upper_alt_in_o[47:16], 32'h40000000);
    check("upper_in_lo", upper_alt_in_o[15:0], 16'h0001);
    // A reset in mid-run must clear selectors that hold non-zero values.
    reset_i <= 1'b1;
    tick(2);
    reset_i <= 1'b0;
    tick(1);
    apb(1'b0, PFS_ADDR_SEL_LOW, 32'h0, PFS_RESET_SEL_LOW, 1'b0);
    apb(1'b0, PFS_ADDR_SEL_HIGH, 32'h0, PFS_RESET_SEL_HIGH, 1'b0);
    print_verdict();
  end
  initial begin
    repeat (2000) @(posedge clock_i);
    bad_count++;
    print_verdict();
  end
endmodule // tb_port_pin_function_select
`default_nettype wire

/* verilog/pfs_pin_mux.sv */
// Pin function multiplexer for a 32-pin port, with two selector registers on an APB slave.
// Assumes pad inputs are asynchronous, peripheral signals are on clock_i, and the GPIO port lives elsewhere.
//
// Contract
// R01: Selector register fields steer each pin to GPIO or one peripheral signal.
// R02: A selected function excludes all other functions on that pin completely; the converter taps of pins 10 to 12 follow the pin under any selection.
// R03: Converter inputs always see their pin level whatever the selector chooses.
// R04: Analog path enabled and conversions valid only when analog input selected.
// R05: Direction bit acts only under GPIO; peripherals set direction themselves.
// R06: Software routes a peripheral to pins before enabling it or its interrupts.
// R07: An enabled but unrouted peripheral has no defined behaviour for software.
// R08: Exactly two read/write 32-bit selector registers at the two fixed addresses.
// R09: Reset clears both selector registers, selecting GPIO on every pin.
// R10: Pins 0 to 3 alternates: UART A, I2C A, timer 3 and timer 0.
// R11: Pins 4 to 7 alternates: SPI A, timer 0 and timer 2 signals.
// R12: Pins 8 to 11 alternates: UART B, timer 2, timer 1, converter inputs.
// R13: Pins 12 to 15 alternates: UART B modem, interrupts, timer 1, SSP, converter.
// R14: Selector codes: 00 primary, 01 first, 10 second, 11 third alternate.
// R15: High register holds pins 16 to 31 ascending, last pin at bits 31:30.
// R16: A write routes from the next cycle; reads return last written fields.
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_mux (
  input wire logic clock_i, // System clock, 10 MHz.
  input wire logic reset_i, // Synchronous reset, active high.
  input wire logic clk_en_i, // Clock enable; all state holds while low.
  input wire logic [31:0] paddr_i, // APB address.
  input wire logic psel_i, // APB select.
  input wire logic penable_i, // APB enable.
  input wire logic pwrite_i, // APB direction, high for write.
  input wire logic [31:0] pwdata_i, // APB write data.
  output logic [31:0] prdata_o, // APB read data.
  output logic pready_o, // APB ready.
  output logic pslverr_o, // APB error, unmapped address.
  input wire logic [31:0] pad_in_i, // Pad input levels, asynchronous.
  output logic [31:0] pad_out_o, // Pad output levels.
  output logic [31:0] pad_oe_n_o, // Pad output enables, low drives.
  output logic [31:0] pad_digital_en_o, // Digital pad section enabled.
  input wire logic [31:0] gpio_out_i, // GPIO output levels.
  input wire logic [31:0] port_direction_reg_i, // GPIO direction, high is output.
  output logic [31:0] gpio_in_o, // GPIO input levels.
  input wire logic uart_a_transmit_i, // UART A transmit data.
  input wire logic t3_match_1_i, // Timer 3 match 1.
  input wire logic t3_match_2_i, // Timer 3 match 2.
  input wire logic i2c_a_clock_drive_low_i, // I2C A clock pull low.
  input wire logic i2c_a_data_drive_low_i, // I2C A data pull low.
  input wire logic t0_match_0_i, // Timer 0 match 0.
  input wire logic spi_a_clock_out_i, // SPI A clock out.
  input wire logic spi_a_clock_oe_n_i, // SPI A clock enable, low drives.
  input wire logic spi_a_master_in_out_i, // SPI A master-in line out.
  input wire logic spi_a_master_in_oe_n_i, // SPI A master-in enable, low drives.
  input wire logic spi_a_master_out_out_i, // SPI A master-out line out.
  input wire logic spi_a_master_out_oe_n_i, // SPI A master-out enable, low drives.
  input wire logic t0_match_1_i, // Timer 0 match 1.
  input wire logic t2_match_0_i, // Timer 2 match 0.
  input wire logic uart_b_transmit_i, // UART B transmit data.
  input wire logic t2_match_1_i, // Timer 2 match 1.
  input wire logic t2_match_2_i, // Timer 2 match 2.
  input wire logic uart_b_request_send_i, // UART B request to send.
  input wire logic t1_match_0_i, // Timer 1 match 0.
  input wire logic t1_match_1_i, // Timer 1 match 1.
  input wire logic uart_b_terminal_ready_i, // UART B terminal ready.
  input wire logic ssp_serial_clock_out_i, // SSP clock out.
  input wire logic ssp_serial_clock_oe_n_i, // SSP clock enable, low drives.
  output logic uart_a_receive_o, // UART A receive data.
  output logic i2c_a_clock_o, // I2C A clock level.
  output logic i2c_a_data_o, // I2C A data level.
  output logic t0_capture_0_o, // Timer 0 capture 0.
  output logic spi_a_clock_o, // SPI A clock level.
  output logic spi_a_master_in_o, // SPI A master-in level.
  output logic spi_a_master_out_o, // SPI A master-out level.
  output logic t0_capture_1_o, // Timer 0 capture 1.
  output logic t0_capture_2_o, // Timer 0 capture 2.
  output logic spi_a_select_o, // SPI A slave select.
  output logic uart_b_receive_o, // UART B receive data.
  output logic t1_capture_0_o, // Timer 1 capture 0.
  output logic uart_b_clear_send_o, // UART B clear to send.
  output logic t1_capture_1_o, // Timer 1 capture 1.
  output logic uart_b_data_set_ready_o, // UART B data set ready.
  output logic ext_irq_1_o, // External interrupt 1.
  output logic ext_irq_2_o, // External interrupt 2.
  output logic ssp_serial_clock_o, // SSP clock level.
  output logic uart_b_carrier_detect_o, // UART B carrier detect.
  output logic uart_b_ring_o, // UART B ring indicator.
  output logic [2:0] adc_level_o, // Pin level seen by converter channels 3..5.
  output logic [2:0] adc_valid_o, // Converter channels 3..5 routed, results valid.
  input wire logic [47:0] upper_alt_out_i, // Pins 16..31 alternate outputs, index 3*(pin-16)+code-1.
  input wire logic [47:0] upper_alt_oe_n_i, // Pins 16..31 alternate enables, low drives.
  output logic [47:0] upper_alt_in_o // Pins 16..31 alternate inputs.
);
  import pfs_pkg::*;

  // Field of the combined 64-bit selector for pin p.
  function automatic logic [1:0] field_of(input logic [63:0] sel, input int p);
    field_of = sel[p*PFS_FIELD_W +: PFS_FIELD_W];
  endfunction

  function automatic logic addr_is(input logic [31:0] addr, input logic [31:0] base);
    addr_is = (addr == base);
  endfunction

  logic [31:0] sel_low_r;
  logic [31:0] sel_high_r;
  logic [63:0] sel_all;
  logic [31:0] pad_meta_r;
  logic [31:0] pad_sync_r;
  logic [31:0] prdata_r;
  logic slverr_r;
  logic cap_r;
  logic setup;
  logic access_done;
  logic hit_low;
  logic hit_high;
  logic [31:0][3:1] alt_out;
  logic [31:0][3:1] alt_oe_n;
  logic [31:0][3:1] alt_in_r;
  logic [31:0] pad_out_nxt;
  logic [31:0] pad_oe_n_nxt;
  logic [31:0] analog_sel;
  logic [31:0] gpio_in_r;
  logic [31:0] pad_out_r;
  logic [31:0] pad_oe_n_r;
  logic [31:0] digital_en_r;
  logic [2:0] adc_level_r;
  logic [2:0] adc_valid_r;

  assign sel_all = {sel_high_r, sel_low_r}; // R15

  // APB slave: zero wait states, read data captured in the setup cycle.
  assign setup = psel_i & ~penable_i;
  assign hit_low = addr_is(paddr_i, PFS_ADDR_SEL_LOW);
  assign hit_high = addr_is(paddr_i, PFS_ADDR_SEL_HIGH);
  // A setup cycle lost to a low clock enable leaves cap_r clear, so ready never comes for that transfer.
  assign pready_o = psel_i & penable_i & clk_en_i & cap_r;
  assign access_done = pready_o;
  assign pslverr_o = pready_o & slverr_r;
  assign prdata_o = prdata_r;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      prdata_r <= PFS_RDATA_UNMAPPED;
      slverr_r <= 1'b0;
      cap_r <= 1'b0;
    end else if (clk_en_i) begin
      if (setup) begin
        cap_r <= 1'b1;
        slverr_r <= ~(hit_low | hit_high);
        if (hit_low) begin
          prdata_r <= sel_low_r; // R16
        end else if (hit_high) begin
          prdata_r <= sel_high_r; // R16
        end else begin
          prdata_r <= PFS_RDATA_UNMAPPED;
        end
      end else if (access_done) begin
        cap_r <= 1'b0;
      end
    end
  end

  // Selector registers; every bit is stored, so reserved codes read back as written.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sel_low_r <= PFS_RESET_SEL_LOW; // R09
      sel_high_r <= PFS_RESET_SEL_HIGH; // R09
    end else if (clk_en_i && access_done && pwrite_i) begin
      if (hit_low) begin
        sel_low_r <= pwdata_i; // R08
      end
      if (hit_high) begin
        sel_high_r <= pwdata_i; // R08
      end
    end
  end

  // Two-stage synchroniser for the pad inputs.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pad_meta_r <= 32'h00000000;
      pad_sync_r <= 32'h00000000;
    end else if (clk_en_i) begin
      pad_meta_r <= pad_in_i;
      pad_sync_r <= pad_meta_r;
    end
  end

  // Peripheral drive per pin and code; reserved slots release the pad.
  always_comb begin
    alt_out = '0;
    alt_oe_n = '1;
    alt_out[0][1] = uart_a_transmit_i; // R10
    alt_oe_n[0][1] = 1'b0;
    alt_out[0][2] = t3_match_1_i;
    alt_oe_n[0][2] = 1'b0;
    alt_out[1][2] = t3_match_2_i;
    alt_oe_n[1][2] = 1'b0;
    // I2C pads are open drain: the pad only ever pulls low.
    alt_oe_n[2][1] = ~i2c_a_clock_drive_low_i;
    alt_oe_n[3][1] = ~i2c_a_data_drive_low_i;
    alt_out[3][2] = t0_match_0_i;
    alt_oe_n[3][2] = 1'b0;
    alt_out[4][1] = spi_a_clock_out_i; // R11
    alt_oe_n[4][1] = spi_a_clock_oe_n_i;
    alt_out[5][1] = spi_a_master_in_out_i;
    alt_oe_n[5][1] = spi_a_master_in_oe_n_i;
    alt_out[5][2] = t0_match_1_i;
    alt_oe_n[5][2] = 1'b0;
    alt_out[6][1] = spi_a_master_out_out_i;
    alt_oe_n[6][1] = spi_a_master_out_oe_n_i;
    alt_out[7][2] = t2_match_0_i;
    alt_oe_n[7][2] = 1'b0;
    alt_out[8][1] = uart_b_transmit_i; // R12
    alt_oe_n[8][1] = 1'b0;
    alt_out[8][2] = t2_match_1_i;
    alt_oe_n[8][2] = 1'b0;
    alt_out[9][2] = t2_match_2_i;
    alt_oe_n[9][2] = 1'b0;
    alt_out[10][1] = uart_b_request_send_i;
    alt_oe_n[10][1] = 1'b0;
    alt_out[12][2] = t1_match_0_i; // R13
    alt_oe_n[12][2] = 1'b0;
    alt_out[13][2] = t1_match_1_i;
    alt_oe_n[13][2] = 1'b0;
    alt_out[13][3] = uart_b_terminal_ready_i;
    alt_oe_n[13][3] = 1'b0;
    alt_out[14][2] = ssp_serial_clock_out_i;
    alt_oe_n[14][2] = ssp_serial_clock_oe_n_i;
    for (int p = PFS_PINS_PER_REG; p < PFS_PINS; p++) begin
      for (int c = 1; c <= PFS_ALT_CODES; c++) begin
        alt_out[p][c] = upper_alt_out_i[(p-PFS_PINS_PER_REG)*PFS_ALT_CODES+c-1];
        alt_oe_n[p][c] = upper_alt_oe_n_i[(p-PFS_PINS_PER_REG)*PFS_ALT_CODES+c-1];
      end
    end
  end

  // Per-pin multiplexer.
  genvar gp;
  generate
    for (gp = 0; gp < PFS_PINS; gp++) begin : g_pin
      logic [1:0] fsel;
      assign fsel = field_of(sel_all, gp); // R01
      assign analog_sel[gp] = PFS_ANALOG_ALT3_MASK[gp] & (fsel == PFS_SEL_ALT3); // R04

      always_comb begin
        case (fsel) // R14
          PFS_SEL_PRIMARY: begin
            pad_out_nxt[gp] = gpio_out_i[gp];
            pad_oe_n_nxt[gp] = ~port_direction_reg_i[gp]; // R05
          end
          PFS_SEL_ALT1: begin
            pad_out_nxt[gp] = alt_out[gp][1];
            pad_oe_n_nxt[gp] = alt_oe_n[gp][1]; // R05
          end
          PFS_SEL_ALT2: begin
            pad_out_nxt[gp] = alt_out[gp][2];
            pad_oe_n_nxt[gp] = alt_oe_n[gp][2];
          end
          PFS_SEL_ALT3: begin
            pad_out_nxt[gp] = alt_out[gp][3];
            pad_oe_n_nxt[gp] = alt_oe_n[gp][3];
          end
          default: begin
            pad_out_nxt[gp] = 1'b0;
            pad_oe_n_nxt[gp] = 1'b1;
          end
        endcase
      end

      // Digital inputs reach only the selected function; all others read zero.
      always_ff @(posedge clock_i) begin
        if (reset_i) begin
          alt_in_r[gp] <= 3'h0;
          gpio_in_r[gp] <= 1'b0;
        end else if (clk_en_i) begin
          for (int c = 1; c <= PFS_ALT_CODES; c++) begin
            alt_in_r[gp][c] <= pad_sync_r[gp] & (fsel == 2'(c)) & ~analog_sel[gp]; // R02
          end
          gpio_in_r[gp] <= pad_sync_r[gp] & (fsel == PFS_SEL_PRIMARY); // R02
        end
      end
    end
  endgenerate

  // Registered pad drive; an analog selection releases the pad and turns its digital section off.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pad_out_r <= 32'h00000000;
      pad_oe_n_r <= 32'hffffffff;
      digital_en_r <= 32'hffffffff;
    end else if (clk_en_i) begin
      pad_out_r <= pad_out_nxt; // R01
      pad_oe_n_r <= pad_oe_n_nxt; // R02
      digital_en_r <= ~analog_sel; // R04
    end
  end

  // The converter tap follows the pin under any selection; only validity depends on routing.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      adc_level_r <= 3'h0;
      adc_valid_r <= 3'h0;
    end else if (clk_en_i) begin
      adc_level_r <= {pad_sync_r[PFS_PIN_ADC5], pad_sync_r[PFS_PIN_ADC4], pad_sync_r[PFS_PIN_ADC3]}; // R03
      adc_valid_r <= {analog_sel[PFS_PIN_ADC5], analog_sel[PFS_PIN_ADC4], analog_sel[PFS_PIN_ADC3]}; // R04
    end
  end

  assign pad_out_o = pad_out_r;
  assign pad_oe_n_o = pad_oe_n_r;
  assign pad_digital_en_o = digital_en_r;
  assign gpio_in_o = gpio_in_r;
  assign adc_level_o = adc_level_r;
  assign adc_valid_o = adc_valid_r;

  // Peripheral inputs; an unrouted peripheral sees a constant zero.
  assign uart_a_receive_o = alt_in_r[1][1]; // R10
  assign i2c_a_clock_o = alt_in_r[2][1];
  assign t0_capture_0_o = alt_in_r[2][2];
  assign i2c_a_data_o = alt_in_r[3][1];
  assign spi_a_clock_o = alt_in_r[4][1]; // R11
  assign t0_capture_1_o = alt_in_r[4][2];
  assign spi_a_master_in_o = alt_in_r[5][1];
  assign spi_a_master_out_o = alt_in_r[6][1];
  assign t0_capture_2_o = alt_in_r[6][2];
  assign spi_a_select_o = alt_in_r[7][1];
  assign uart_b_receive_o = alt_in_r[9][1]; // R12
  assign t1_capture_0_o = alt_in_r[10][2];
  assign uart_b_clear_send_o = alt_in_r[11][1];
  assign t1_capture_1_o = alt_in_r[11][2];
  assign uart_b_data_set_ready_o = alt_in_r[12][1]; // R13
  assign ext_irq_1_o = alt_in_r[14][1];
  assign ssp_serial_clock_o = alt_in_r[14][2];
  assign uart_b_carrier_detect_o = alt_in_r[14][3];
  assign ext_irq_2_o = alt_in_r[15][1];
  assign uart_b_ring_o = alt_in_r[15][3];

  generate
    for (gp = PFS_PINS_PER_REG; gp < PFS_PINS; gp++) begin : g_upper
      assign upper_alt_in_o[(gp-PFS_PINS_PER_REG)*PFS_ALT_CODES +: PFS_ALT_CODES] = alt_in_r[gp]; // R15
    end
  endgenerate

endmodule // pfs_pin_mux
`default_nettype wire

/* verilog/pfs_pkg.sv */
// Constants for the port pin function select block: register map, field layout and selector codes.
// Assumes a 32-pin general-purpose port whose pins are shared with on-chip peripherals.
`default_nettype none
package pfs_pkg;

  // Register byte addresses on the peripheral bus.
  localparam logic [31:0] PFS_ADDR_SEL_LOW = 32'he002c000;
  localparam logic [31:0] PFS_ADDR_SEL_HIGH = 32'he002c004;

  // Reset values of both selector registers; zero selects GPIO on every pin.
  localparam logic [31:0] PFS_RESET_SEL_LOW = 32'h00000000;
  localparam logic [31:0] PFS_RESET_SEL_HIGH = 32'h00000000;

  // Field layout: one 2-bit field per pin, pin n of a register at bits 2n+1:2n.
  localparam int PFS_FIELD_W = 2;
  localparam int PFS_PINS = 32;
  localparam int PFS_PINS_PER_REG = 16;
  localparam int PFS_ALT_CODES = 3;

  // Selector codes.
  typedef enum logic [1:0] {
    PFS_SEL_PRIMARY = 2'h0,
    PFS_SEL_ALT1 = 2'h1,
    PFS_SEL_ALT2 = 2'h2,
    PFS_SEL_ALT3 = 2'h3
  } pfs_sel_t;

  // Pins whose third alternate is an analog converter input.
  localparam logic [31:0] PFS_ANALOG_ALT3_MASK = 32'h00001c00;

  // Pins hosting converter channels 3, 4 and 5.
  localparam int PFS_PIN_ADC3 = 10;
  localparam int PFS_PIN_ADC4 = 11;
  localparam int PFS_PIN_ADC5 = 12;

  // Read value of an unmapped address.
  localparam logic [31:0] PFS_RDATA_UNMAPPED = 32'h00000000;

endpackage
`default_nettype wire
